// ===== design/fbp_block_protect.sv
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
module fbp_block_protect (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic I_CE,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_FLASH_RD_VALID,
  input wire logic [7:0] I_FLASH_RD_DATA,
  output logic O_FLASH_RD_REQ,
  output logic [15:0] O_FLASH_RD_ADDR,
  input wire logic I_FLASH_PROG,
  input wire logic [15:0] I_FLASH_PROG_ADDR,
  input wire logic [7:0] I_FLASH_PROG_DATA,
  input wire logic I_TEST_ENTRY_VOLTAGE,
  output logic O_HIGH_VOLTAGE_ENABLE,
  output logic O_PROGRAM_SELECT,
  output logic O_ERASE_SELECT,
  output logic O_MASS_SELECT,
  output logic [15:0] O_TARGET_ADDR,
  output logic O_TARGET_PROTECTED,
  output logic O_LOADED
);

  fbp_pkg::fbp_load_t ld_reg;
  fbp_pkg::fbp_load_t ld_next;
  fbp_pkg::fbp_ctl_t ctl_reg;
  fbp_pkg::fbp_ctl_t ctl_next;
  logic [15:0] target_reg;
  logic [15:0] target_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [7:0] protect_start_bits;
  logic store_we;
  logic [7:0] store_wdata;
  logic [15:0] start_addr;
  logic any_protect;
  logic target_prot;
  logic byte_prot;
  logic prog_hit;
  logic bus_wr;
  logic bus_rd;

  // The mirror of the protect byte; only the load and program paths write it.
  fbp_protect_store u_store (
    .i_clk(I_CLK),
    .i_arst_n(I_ARST_N),
    .i_ce(I_CE),
    .i_we(store_we),
    .i_wdata(store_wdata),
    .o_rdata(protect_start_bits)
  );

  // Start address from the protect bits on a 64-byte grid.
  assign start_addr = {fbp_pkg::START_TOP_BITS, protect_start_bits,
                       fbp_pkg::START_LOW_BITS};
  assign any_protect = (protect_start_bits != fbp_pkg::PROTECT_ERASED);
  // Values up to B8 yield starts at or below EE00, so the array is covered.
  assign target_prot = any_protect && (target_reg >= start_addr)
                       && (target_reg <= fbp_pkg::FLASH_LAST_ADDR);
  // With FE the start is FF80; any protected value shields the protect byte unless the test entry voltage is high.
  assign byte_prot = any_protect && !I_TEST_ENTRY_VOLTAGE;

  // Mirror the stored byte: loaded after reset, then tracks its programming while unprotected or at test entry voltage.
  assign prog_hit = I_FLASH_PROG && (I_FLASH_PROG_ADDR == fbp_pkg::PROTECT_BYTE_ADDR);

  always_comb begin
    ld_next = ld_reg;
    store_we = 1'b0;
    store_wdata = I_FLASH_RD_DATA;
    case (ld_reg)
      fbp_pkg::LD_IDLE: begin
        // One idle cycle after reset lets the array settle before the fetch.
        ld_next = fbp_pkg::LD_READ;
      end
      fbp_pkg::LD_READ: begin
        // The request stays up for as long as the array takes to answer.
        if (I_FLASH_RD_VALID) begin
          store_we = 1'b1;
          ld_next = fbp_pkg::LD_DONE;
        end
      end
      fbp_pkg::LD_DONE: begin
        if (prog_hit && !byte_prot) begin
          store_we = 1'b1;
          // Programming can only clear bits: the stored byte is ANDed with the data.
          store_wdata = I_FLASH_PROG_DATA & protect_start_bits;
        end
      end
      default: begin
        // An unknown state restarts the fetch rather than trust the mirrored byte.
        ld_next = fbp_pkg::LD_IDLE;
      end
    endcase
  end

  // Writes take effect at the access edge; reads are captured at the setup edge so that
  // the read data leave a register and stand through the whole access phase.
  assign bus_wr = I_PSEL && I_PENABLE && I_PWRITE;
  assign bus_rd = I_PSEL && !I_PENABLE && !I_PWRITE;

  // Control register: operation select interlock and the high-voltage gate.
  always_comb begin
    ctl_next = ctl_reg;
    if (bus_wr && (I_PADDR == fbp_pkg::OFF_CONTROL)) begin
      ctl_next.program_select = I_PWDATA[fbp_pkg::CTL_PGM_BIT];
      ctl_next.erase = I_PWDATA[fbp_pkg::CTL_ERASE_BIT];
      ctl_next.mass = I_PWDATA[fbp_pkg::CTL_MASS_BIT];
      // Program and erase are interlocked: asking for both keeps the old pair.
      if (ctl_next.program_select && ctl_next.erase) begin
        ctl_next.program_select = ctl_reg.program_select;
        ctl_next.erase = ctl_reg.erase;
      end
      // High voltage only for a selected, unprotected, permitted operation.
      // It is judged against the target already latched, so set the target first.
      ctl_next.high_voltage_enable = I_PWDATA[fbp_pkg::CTL_HIGH_VOLTAGE_ENABLE_BIT]
                      && (ctl_next.program_select || ctl_next.erase)
                      && !target_prot
                      && !(ctl_next.erase && ctl_next.mass && any_protect);
    end
  end

  always_comb begin
    target_next = target_reg;
    if (bus_wr && (I_PADDR == fbp_pkg::OFF_TARGET)) begin
      target_next = I_PWDATA[15:0];
    end
    // The protect-start offset has no write path; a bus write there changes nothing.
    if (bus_wr && (I_PADDR == fbp_pkg::OFF_PROTECT_START)) begin
      target_next = target_reg;
    end
  end

  // Read data for the addressed register, captured in the setup phase.
  always_comb begin
    rdata_next = rdata_reg;
    if (bus_rd) begin
      case (I_PADDR)
        fbp_pkg::OFF_PROTECT_START: rdata_next = {24'h000000, protect_start_bits};
        fbp_pkg::OFF_CONTROL: rdata_next = {28'h0000000, ctl_reg};
        fbp_pkg::OFF_TARGET: rdata_next = {16'h0000, target_reg};
        // Status: bit 2 loaded, bit 1 any protection, bit 0 target protected.
        fbp_pkg::OFF_STATUS: rdata_next = {29'h0000000, ld_reg == fbp_pkg::LD_DONE,
                                           any_protect, target_prot};
        fbp_pkg::OFF_START_ADDR: rdata_next = {16'h0000, start_addr};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  // All state holds while the clock enable is low.
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ld_reg <= fbp_pkg::LD_IDLE;
    end else if (I_CE) begin
      ld_reg <= ld_next;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ctl_reg <= fbp_pkg::CTL_RESET;
    end else if (I_CE) begin
      ctl_reg <= ctl_next;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      target_reg <= fbp_pkg::TARGET_RESET;
    end else if (I_CE) begin
      target_reg <= target_next;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rdata_reg <= 32'h00000000;
    end else if (I_CE) begin
      rdata_reg <= rdata_next;
    end
  end

  // Every access completes with no wait state and no error.
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = 1'b0;
  assign O_PRDATA = rdata_reg;

  // The fetch address is fixed: the protect byte has one home in the array.
  assign O_FLASH_RD_REQ = (ld_reg == fbp_pkg::LD_READ);
  assign O_FLASH_RD_ADDR = fbp_pkg::PROTECT_BYTE_ADDR;

  assign O_HIGH_VOLTAGE_ENABLE = ctl_reg.high_voltage_enable;
  assign O_PROGRAM_SELECT = ctl_reg.program_select;
  assign O_ERASE_SELECT = ctl_reg.erase;
  assign O_MASS_SELECT = ctl_reg.mass;
  assign O_TARGET_ADDR = target_reg;
  assign O_TARGET_PROTECTED = target_prot;
  assign O_LOADED = (ld_reg == fbp_pkg::LD_DONE);

endmodule : fbp_block_protect

// ===== design/fbp_pkg.sv
package fbp_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;

  // Register offsets on the APB bus (byte addresses).
  localparam logic [11:0] OFF_PROTECT_START = 12'h000;
  localparam logic [11:0] OFF_CONTROL = 12'h004;
  localparam logic [11:0] OFF_TARGET = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00C;
  localparam logic [11:0] OFF_START_ADDR = 12'h010;

  // Control register field positions.
  localparam int unsigned CTL_PGM_BIT = 0;
  localparam int unsigned CTL_ERASE_BIT = 1;
  localparam int unsigned CTL_MASS_BIT = 2;
  localparam int unsigned CTL_HIGH_VOLTAGE_ENABLE_BIT = 3;

  // Flash array location of the protect byte and its erased value.
  localparam logic [ADDR_W-1:0] PROTECT_BYTE_ADDR = 16'hFFBE;
  localparam logic [7:0] PROTECT_ERASED = 8'hFF;
  localparam logic [1:0] START_TOP_BITS = 2'h3;
  localparam logic [5:0] START_LOW_BITS = 6'h00;
  localparam logic [ADDR_W-1:0] FLASH_LAST_ADDR = 16'hFFFF;
  localparam logic [7:0] WHOLE_PROTECT_LIMIT = 8'hB8;

  localparam logic [7:0] PROTECT_RESET = 8'hFF;
  localparam logic [ADDR_W-1:0] TARGET_RESET = 16'h0000;

  typedef struct packed {
    logic high_voltage_enable;
    logic mass;
    logic erase;
    logic program_select;
  } fbp_ctl_t;

  localparam fbp_ctl_t CTL_RESET = '{high_voltage_enable: 1'b0, mass: 1'b0, erase: 1'b0, program_select: 1'b0};

  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_READ = 2'b01,
    LD_DONE = 2'b10
  } fbp_load_t;

endpackage : fbp_pkg

// ===== design/fbp_protect_store.sv
`timescale 1ns/100ps
// Holds the protect byte mirrored from the flash array; data leave a register.
module fbp_protect_store (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_we,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);

  logic [7:0] store_reg;
  logic [7:0] store_next;

  always_comb begin
    store_next = store_reg;
    if (i_we) begin
      store_next = i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      store_reg <= fbp_pkg::PROTECT_RESET;
    end else if (i_ce) begin
      store_reg <= store_next;
    end
  end

  assign o_rdata = store_reg;

endmodule : fbp_protect_store

// ===== bench/fbp_block_protect_properties.sv
`timescale 1ns/100ps
module fbp_block_protect_properties (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic I_CE,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic I_FLASH_RD_VALID,
  input wire logic O_FLASH_RD_REQ,
  input wire logic [15:0] O_FLASH_RD_ADDR,
  input wire logic O_HIGH_VOLTAGE_ENABLE,
  input wire logic O_PROGRAM_SELECT,
  input wire logic O_ERASE_SELECT,
  input wire logic [15:0] O_TARGET_ADDR,
  input wire logic O_TARGET_PROTECTED,
  input wire logic O_LOADED
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);
  sequence load_taken;
    I_CE && O_FLASH_RD_REQ && I_FLASH_RD_VALID;
  endsequence
  chk_fetch_addr: assert property (O_FLASH_RD_ADDR == 16'hFFBE)
    else $error("protect byte fetch address wrong");
  chk_load_done: assert property (load_taken |=> O_LOADED && !O_FLASH_RD_REQ)
    else $error("protect byte load not completed");
  chk_loaded_stays: assert property (O_LOADED |=> O_LOADED)
    else $error("loaded flag dropped");
  chk_req_fall: assert property ($fell(O_FLASH_RD_REQ) |-> O_LOADED)
    else $error("fetch request ended without load");
  chk_high_voltage_enable_safe: assert property ($rose(O_HIGH_VOLTAGE_ENABLE) |-> !$past(O_TARGET_PROTECTED))
    else $error("high voltage enabled on protected target");
  chk_ready_zero: assert property (I_PSEL && I_PENABLE |-> O_PREADY && !O_PSLVERR)
    else $error("bus answer not ready or error");
  chk_target_write: assert property ($changed(O_TARGET_ADDR)
    |-> $past(I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == 12'h008))
    else $error("target address changed without write");
  chk_sel_excl: assert property (!(O_PROGRAM_SELECT && O_ERASE_SELECT))
    else $error("program and erase selected together");
endmodule : fbp_block_protect_properties

// ===== bench/fbp_flash_model.sv
`timescale 1ns/100ps
module fbp_flash_model (
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_byte,
  output logic o_valid,
  output logic [7:0] o_data
);
  logic [1:0] wait_cnt = 2'h0;
  initial o_valid = 1'b0;
  initial o_data = 8'h00;
  // Idle data toggle so a stale byte is never mistaken for a fresh one.
  always @(posedge i_clk) begin
    o_valid <= 1'b0;
    o_data <= ~o_data;
    if (i_req && !o_valid) begin
      wait_cnt <= wait_cnt + 2'h1;
      if (wait_cnt == 2'h3 && i_addr == 16'hFFBE) begin
        o_valid <= 1'b1;
        o_data <= i_byte;
      end
    end
  end
endmodule : fbp_flash_model

// ===== bench/fbp_block_protect_tb_top.sv
`timescale 1ns/100ps
module fbp_block_protect_tb_top;
  logic I_CLK, I_ARST_N, I_CE, I_PSEL, I_PENABLE, I_PWRITE, O_PREADY, O_PSLVERR, O_LOADED;
  logic I_FLASH_RD_VALID, O_FLASH_RD_REQ, I_FLASH_PROG, I_TEST_ENTRY_VOLTAGE;
  logic O_HIGH_VOLTAGE_ENABLE, O_PROGRAM_SELECT, O_ERASE_SELECT, O_MASS_SELECT, O_TARGET_PROTECTED;
  logic [11:0] I_PADDR;
  logic [31:0] I_PWDATA, O_PRDATA, rd;
  logic [7:0] I_FLASH_RD_DATA, I_FLASH_PROG_DATA, mem_byte;
  logic [15:0] O_FLASH_RD_ADDR, I_FLASH_PROG_ADDR, O_TARGET_ADDR, start;
  int bad_count = 0;
  int n_tests = 0;
  fbp_block_protect u_dut (.*);
  fbp_flash_model u_flash (.i_clk(I_CLK), .i_req(O_FLASH_RD_REQ), .i_addr(O_FLASH_RD_ADDR),
    .i_byte(mem_byte), .o_valid(I_FLASH_RD_VALID), .o_data(I_FLASH_RD_DATA));
  initial begin
    I_CLK = 1'b0;
    forever #12.5 I_CLK = ~I_CLK;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge I_CLK);
    I_PSEL <= 1'b1;
    I_PWRITE <= w;
    I_PADDR <= a;
    I_PWDATA <= d;
    @(posedge I_CLK);
    I_PENABLE <= 1'b1;
    do begin
      @(posedge I_CLK);
    end while (O_PREADY !== 1'b1);
    rd = O_PRDATA;
    I_PSEL <= 1'b0;
    I_PENABLE <= 1'b0;
  endtask : xfer
  task automatic boot(input logic [7:0] b);
    mem_byte = b;
    I_ARST_N <= 1'b0;
    repeat (3) @(posedge I_CLK);
    I_ARST_N <= 1'b1;
    for (int i = 0; i < 20 && O_LOADED !== 1'b1; i++) @(posedge I_CLK);
    chk("loaded", 1, O_LOADED);
  endtask : boot
  task automatic prog(input logic [7:0] d);
    @(posedge I_CLK);
    I_FLASH_PROG <= 1'b1;
    I_FLASH_PROG_DATA <= d;
    @(posedge I_CLK);
    I_FLASH_PROG <= 1'b0;
    xfer(0, 12'h000, 0);
  endtask : prog
  task automatic test_decode;
    logic [7:0] vals [6] = '{8'h00, 8'hB8, 8'hB9, 8'hDF, 8'hFE, 8'hFF};
    foreach (vals[k]) begin
      boot(vals[k]);
      start = {2'b11, vals[k], 6'h00};
      xfer(0, 12'h010, 0);
      chk("start", {16'h0, start}, rd);
      xfer(0, 12'h00C, 0);
      chk("any", vals[k] != 8'hFF, rd[1]);
      xfer(1, 12'h008, start - 16'h1);
      xfer(0, 12'h00C, 0);
      chk("below", 0, rd[0]);
      for (int j = 0; j < 2; j++) begin
        xfer(1, 12'h008, j ? 16'hFFFF : start);
        xfer(0, 12'h00C, 0);
        chk("covered", vals[k] != 8'hFF, rd[0]);
        chk("prot pin", vals[k] != 8'hFF, O_TARGET_PROTECTED);
        chk("target pin", j ? 16'hFFFF : start, O_TARGET_ADDR);
      end
      xfer(1, 12'h008, 32'hEE00);
      xfer(0, 12'h00C, 0);
      chk("array bottom", vals[k] <= 8'hB8, rd[0]);
    end
    $display("decode test done");
  endtask : test_decode
  task automatic test_high_voltage_enable;
    boot(8'hFE);
    xfer(1, 12'h008, 32'hFF80);
    xfer(1, 12'h004, 32'h1);
    xfer(0, 12'h000, 0);
    xfer(1, 12'h004, 32'h9);
    xfer(0, 12'h004, 0);
    chk("high_voltage_enable blocked", 32'h1, rd);
    xfer(1, 12'h008, 32'hFF7F);
    xfer(1, 12'h004, 32'h9);
    xfer(0, 12'h004, 0);
    chk("high_voltage_enable set", 32'h9, rd);
    xfer(1, 12'h004, 32'h6);
    xfer(0, 12'h000, 0);
    xfer(1, 12'h004, 32'hE);
    xfer(0, 12'h004, 0);
    chk("mass blocked", 32'h6, rd);
    xfer(1, 12'h004, 32'hB);
    xfer(0, 12'h004, 0);
    chk("interlock", 32'hA, rd);
    chk("select pins", 32'h2, {O_MASS_SELECT, O_ERASE_SELECT, O_PROGRAM_SELECT});
    chk("high_voltage_enable pin", 1, O_HIGH_VOLTAGE_ENABLE);
    boot(8'hFF);
    xfer(1, 12'h004, 32'h6);
    xfer(0, 12'h000, 0);
    xfer(1, 12'h004, 32'hE);
    xfer(0, 12'h004, 0);
    chk("mass open", 32'hE, rd);
    chk("mass pin", 1, O_MASS_SELECT);
    $display("high voltage test done");
  endtask : test_high_voltage_enable
  task automatic test_prog;
    boot(8'hFF);
    I_FLASH_PROG_ADDR <= 16'hFFBD;
    prog(8'h00);
    chk("prog other addr", 32'hFF, rd);
    I_FLASH_PROG_ADDR <= 16'hFFBE;
    prog(8'hF0);
    chk("prog open", 32'hF0, rd);
    prog(8'h00);
    chk("prog locked", 32'hF0, rd);
    I_TEST_ENTRY_VOLTAGE <= 1'b1;
    prog(8'h00);
    chk("prog test voltage", 32'h0, rd);
    I_TEST_ENTRY_VOLTAGE <= 1'b0;
    xfer(1, 12'h000, 32'hFF);
    xfer(0, 12'h000, 0);
    chk("bus write", 32'h0, rd);
    $display("program test done");
  endtask : test_prog
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  initial begin
    {I_ARST_N, I_PSEL, I_PENABLE, I_PWRITE, I_FLASH_PROG, I_TEST_ENTRY_VOLTAGE} = '0;
    {I_PADDR, I_PWDATA, I_FLASH_PROG_DATA, mem_byte} = '0;
    I_CE = 1'b1;
    I_FLASH_PROG_ADDR = 16'hFFBE;
    test_decode;
    test_high_voltage_enable;
    test_prog;
    final_report;
  end
  initial begin
    repeat (5000) @(posedge I_CLK);
    bad_count++;
    final_report;
  end
endmodule : fbp_block_protect_tb_top
bind fbp_block_protect fbp_block_protect_properties u_chk (.*);
